// *** common/rfb_defines.svh ***
// register map, field layout and timing constants of the ring fieldbus slave adapter
`ifndef RFB_DEFINES_SVH
`define RFB_DEFINES_SVH

// bus occupancy and string limits
`define RFB_PD_MAX_BYTES     5'd20
`define RFB_STRING_MAX_BYTES 8'd200
`define RFB_BUS_MAX_WORDS    4'd10
`define RFB_PCP_WORDS_NONE   4'd0
`define RFB_PCP_WORDS_ONE    4'd1
`define RFB_PCP_WORDS_TWO    4'd2
`define RFB_PCP_WORDS_FOUR   4'd4

// parameter object index ranges
`define RFB_OBJ_RW_BASE      16'h6000
`define RFB_OBJ_RO_BASE      16'h6040
`define RFB_OBJ_END          16'h6080
`define RFB_OBJ_DEPTH        128
`define RFB_OBJ_AW           7

// indicator hold time
`define RFB_HOLD_TIME_MS     600
`define RFB_CLK_KHZ          200000

// register word offsets
`define RFB_REG_CTRL         4'h0
`define RFB_REG_PARAM_LEN    4'h1
`define RFB_REG_ID           4'h2
`define RFB_REG_STATUS       4'h3
`define RFB_REG_IRQ_STAT     4'h4
`define RFB_REG_IRQ_MASK     4'h5
`define RFB_REG_OBJ_INDEX    4'h6
`define RFB_REG_OBJ_DATA     4'h7
`define RFB_REG_PD_SEL       4'h8
`define RFB_REG_PD_OUT       4'h9
`define RFB_REG_PD_IN        4'ha

// field positions
`define RFB_CTRL_PCP         1:0
`define RFB_CTRL_PDLEN       12:8
`define RFB_PARAM_LEN        7:0
`define RFB_WORD             15:0
`define RFB_PD_SEL           3:0
`define RFB_STAT_PINS        3:0
`define RFB_STAT_PDW         11:8
`define RFB_STAT_PCPW        15:12

// interrupt status bits
`define RFB_IRQ_SEGOFF       0
`define RFB_IRQ_PCP          1
`define RFB_IRQ_CYCLE        2
`define RFB_IRQ_OBJWR        3
`define RFB_IRQ_OBJERR       4
`define RFB_IRQ_W            5

`endif

// *** common/rfb_pkg.sv ***
// types shared by the ring fieldbus slave adapter
`default_nettype none
package rfb_pkg;
   typedef enum logic [1:0] {PCP_NONE, PCP_ONE, PCP_TWO, PCP_FOUR} rfb_pcp_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_MEM, BUS_MEMRD, BUS_DONE} rfb_bus_state_t;
endpackage
`default_nettype wire

// *** src/rfb_obj_mem.sv ***
// parameter object store, one port, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rfb_defines.svh"
module rfb_obj_mem
(
   input  wire logic                    clk,
   input  wire logic                    ce,
   input  wire logic                    we,
   input  wire logic [`RFB_OBJ_AW-1:0]  addr,
   input  wire logic [15:0]             wdata,
   output var  logic [15:0]             rdata
);
   logic [15:0] mem [0:`RFB_OBJ_DEPTH-1];

   // no reset on the array: unwritten objects read undefined
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (we)
            mem[addr] <= wdata;
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// *** src/rfb_hold_timer.sv ***
// retriggerable hold timer that stretches activity for an indicator
`timescale 1ns/1ps
`default_nettype none
module rfb_hold_timer
#(
   parameter int unsigned HOLD_CYCLES = 1
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic trig,
   output var  logic lit
);
   localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          next_lit;

   always_comb
   begin
      next_cnt = cnt;
      next_lit = lit;
      if (trig)
      begin
         next_cnt = CW'(HOLD_CYCLES - 1);
         next_lit = 1'b1;
      end
      else if (cnt != '0)
         next_cnt = cnt - 1'b1;
      else
         next_lit = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= '0;
         lit <= 1'b0;
      end
      else if (ce)
      begin
         cnt <= next_cnt;
         lit <= next_lit;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   hold_restart_a: assert property (trig |=> lit && cnt == CW'(HOLD_CYCLES - 1))
      else $error("hold timer did not restart on activity");
endmodule
`default_nettype wire

// *** src/rfb_adapter.sv ***
// ring fieldbus slave adapter: bus slots, parameter objects, indicators, register slave
`timescale 1ns/1ps
`default_nettype none
`include "rfb_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - parameter string capped at 200 minus process bytes
// - identity code chosen by parameter channel width
// - objects at 0x6000 read/write, 0x6040 read-only to the link (software writes both)
// - ungrounded sense pin terminates outgoing segment
// - bus-off indicator lit while outgoing segment off
// - traffic indicator lit, held 0.6 s after activity
// - cable indicator: cable good, master not reset
// - bus-active indicator follows link layer activity
// - process data exchanged every bus cycle
// - at most ten words, channel 0/1/2/4 words
module rfb_adapter
#(
   parameter int unsigned HOLD_CYCLES = `RFB_HOLD_TIME_MS * `RFB_CLK_KHZ,
   parameter logic [7:0]  ID_PCP0     = 8'h21, // arbitrary value
   parameter logic [7:0]  ID_PCP1     = 8'h22, // arbitrary value
   parameter logic [7:0]  ID_PCP2     = 8'h23, // arbitrary value
   parameter logic [7:0]  ID_PCP4     = 8'h24  // arbitrary value
)
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   output var  logic        irq,
   input  wire logic        cycle_start,
   input  wire logic        word_strobe,
   input  wire logic [15:0] word_rx,
   output var  logic [15:0] word_tx,
   input  wire logic        obj_req,
   input  wire logic        obj_wr,
   input  wire logic [15:0] obj_index,
   input  wire logic [15:0] obj_wdata,
   output var  logic        obj_ack,
   output var  logic [15:0] obj_rdata,
   output var  logic        obj_err,
   input  wire logic        dll_active,
   input  wire logic        cable_good,
   input  wire logic        bus_master_reset,
   input  wire logic        outgoing_term_sense,
   output var  logic        out_seg_enable,
   output var  logic        out_term_enable,
   output var  logic [7:0]  id_code,
   output var  logic        outgoing_bus_off_led,
   output var  logic        param_traffic_led,
   output var  logic        cable_ok_led,
   output var  logic        bus_active_led
);
   ////////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic [1:0] rst_q;
   logic       rst_n;
   logic [2:0] pin_m;
   logic [2:0] pin_s;
   logic       term_s;
   logic       mreset_s;
   logic       cable_s;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rst_q <= 2'b00;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_m <= 3'h0;
         pin_s <= 3'h0;
      end
      else if (ce)
      begin
         pin_m <= {outgoing_term_sense, bus_master_reset, cable_good};
         pin_s <= pin_m;
      end
   end
   assign {term_s, mreset_s, cable_s} = pin_s;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [3:0] pcp_words_of(input rfb_pkg::rfb_pcp_t sel);
      case (sel)
         rfb_pkg::PCP_ONE:  pcp_words_of = `RFB_PCP_WORDS_ONE;
         rfb_pkg::PCP_TWO:  pcp_words_of = `RFB_PCP_WORDS_TWO;
         rfb_pkg::PCP_FOUR: pcp_words_of = `RFB_PCP_WORDS_FOUR;
         default:           pcp_words_of = `RFB_PCP_WORDS_NONE;
      endcase
   endfunction

   // process bytes may not crowd the channel past the ten-word slot budget
   function automatic logic [4:0] pd_cap(input rfb_pkg::rfb_pcp_t sel);
      logic [4:0] room;
      room = {`RFB_BUS_MAX_WORDS - pcp_words_of(sel), 1'b0};
      pd_cap = (room < `RFB_PD_MAX_BYTES) ? room : `RFB_PD_MAX_BYTES;
   endfunction

   // returns {valid, read_only, slot}
   function automatic logic [8:0] obj_map(input logic [15:0] idx);
      logic ok;
      ok = (idx >= `RFB_OBJ_RW_BASE) && (idx < `RFB_OBJ_END);
      // slot keeps the read-only bit, so both ranges share one store
      obj_map = {ok, idx >= `RFB_OBJ_RO_BASE, idx[`RFB_OBJ_AW-1:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   rfb_pkg::rfb_bus_state_t state, next_state;
   rfb_pkg::rfb_pcp_t       pcp_sel, next_pcp_sel;
   logic [4:0]              pd_len, next_pd_len;
   logic [7:0]              param_len, next_param_len;
   logic [`RFB_IRQ_W-1:0]   irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_ev;
   logic [15:0]             obj_index_r, next_obj_index_r;
   logic [3:0]              pd_sel, next_pd_sel;
   logic [15:0]             pd_out [0:9];
   logic [15:0]             next_pd_out [0:9];
   logic [15:0]             pd_in [0:9];
   logic [31:0]             next_readdata;
   logic                    next_wait, next_irq;
   logic [3:0]              pcp_words, pd_words, slot, next_slot;
   logic [7:0]              id_sel;
   logic [8:0]              sw_map, lk_map;
   logic                    lk_err, lk_p, lk_pwr, lk_perr, pcp_act, in_pcp, seg_off;
   logic                    mem_we;
   logic [`RFB_OBJ_AW-1:0]  mem_addr;
   logic [15:0]             mem_wdata, mem_rdata, next_word_tx;

   assign pcp_words = pcp_words_of(pcp_sel);
   assign pd_words  = 4'((6'(pd_len) + 6'd1) >> 1);
   assign sw_map    = obj_map(obj_index_r);
   assign lk_map    = obj_map(obj_index);
   assign lk_err    = !lk_map[8] || (obj_wr && lk_map[7]);
   assign seg_off   = term_s;
   assign in_pcp    = (slot >= pd_words) && (slot < pd_words + pcp_words);
   assign pcp_act   = (word_strobe && !cycle_start && in_pcp) || obj_req;

   always_comb
   begin
      case (pcp_sel)
         rfb_pkg::PCP_ONE:  id_sel = ID_PCP1;
         rfb_pkg::PCP_TWO:  id_sel = ID_PCP2;
         rfb_pkg::PCP_FOUR: id_sel = ID_PCP4;
         default:           id_sel = ID_PCP0;
      endcase
   end

   always_comb
   begin
      irq_ev = '0;
      irq_ev[`RFB_IRQ_SEGOFF] = seg_off && !outgoing_bus_off_led;
      irq_ev[`RFB_IRQ_PCP]    = pcp_act;
      irq_ev[`RFB_IRQ_CYCLE]  = cycle_start;
      irq_ev[`RFB_IRQ_OBJWR]  = obj_req && obj_wr && !lk_err;
      irq_ev[`RFB_IRQ_OBJERR] = obj_req && lk_err;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // object store: link accesses win, software waits on waitrequest
   always_comb
   begin
      mem_we    = 1'b0;
      mem_addr  = lk_map[`RFB_OBJ_AW-1:0];
      mem_wdata = obj_wdata;
      if (obj_req)
         mem_we = obj_wr && !lk_err;
      else if (state == rfb_pkg::BUS_MEM)
      begin
         mem_addr  = sw_map[`RFB_OBJ_AW-1:0];
         mem_wdata = avs_writedata[`RFB_WORD];
         mem_we    = avs_write;
      end
   end

   rfb_obj_mem i_rfb_obj_mem
   (
      .clk   (clk),
      .ce    (ce),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register slave
   always_comb
   begin
      next_state       = state;
      next_wait        = 1'b1;
      next_readdata    = avs_readdata;
      next_pcp_sel     = pcp_sel;
      next_pd_len      = pd_len;
      next_param_len   = param_len;
      next_irq_mask    = irq_mask;
      next_obj_index_r = obj_index_r;
      next_pd_sel      = pd_sel;
      next_pd_out      = pd_out;
      next_irq_stat    = irq_stat | irq_ev;
      case (state)
         rfb_pkg::BUS_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               next_state    = rfb_pkg::BUS_DONE;
               next_wait     = 1'b0;
               next_readdata = 32'h0000_0000;
               if (avs_address == `RFB_REG_CTRL)
               begin
                  if (avs_write)
                  begin
                     next_pcp_sel = rfb_pkg::rfb_pcp_t'(avs_writedata[`RFB_CTRL_PCP]);
                     next_pd_len  = (avs_writedata[`RFB_CTRL_PDLEN] < pd_cap(next_pcp_sel)) ?
                                    avs_writedata[`RFB_CTRL_PDLEN] : pd_cap(next_pcp_sel);
                     if (param_len > `RFB_STRING_MAX_BYTES - 8'(next_pd_len))
                        next_param_len = `RFB_STRING_MAX_BYTES - 8'(next_pd_len);
                  end
                  next_readdata[`RFB_CTRL_PCP]   = pcp_sel;
                  next_readdata[`RFB_CTRL_PDLEN] = pd_len;
               end
               else if (avs_address == `RFB_REG_PARAM_LEN)
               begin
                  if (avs_write)
                     next_param_len = (avs_writedata[`RFB_PARAM_LEN] > `RFB_STRING_MAX_BYTES - 8'(pd_len)) ?
                                      `RFB_STRING_MAX_BYTES - 8'(pd_len) : avs_writedata[`RFB_PARAM_LEN];
                  next_readdata[`RFB_PARAM_LEN] = param_len;
               end
               else if (avs_address == `RFB_REG_ID)
                  next_readdata[7:0] = id_code;
               else if (avs_address == `RFB_REG_STATUS)
               begin
                  next_readdata[`RFB_STAT_PINS] = {term_s, mreset_s, cable_s, seg_off};
                  next_readdata[`RFB_STAT_PDW]  = pd_words;
                  next_readdata[`RFB_STAT_PCPW] = pcp_words;
               end
               else if (avs_address == `RFB_REG_IRQ_STAT)
               begin
                  // a new event in the clearing cycle survives
                  if (avs_write)
                     next_irq_stat = (irq_stat & ~avs_writedata[`RFB_IRQ_W-1:0]) | irq_ev;
                  next_readdata[`RFB_IRQ_W-1:0] = irq_stat;
               end
               else if (avs_address == `RFB_REG_IRQ_MASK)
               begin
                  if (avs_write)
                     next_irq_mask = avs_writedata[`RFB_IRQ_W-1:0];
                  next_readdata[`RFB_IRQ_W-1:0] = irq_mask;
               end
               else if (avs_address == `RFB_REG_OBJ_INDEX)
               begin
                  if (avs_write)
                     next_obj_index_r = avs_writedata[`RFB_WORD];
                  next_readdata[`RFB_WORD] = obj_index_r;
               end
               else if (avs_address == `RFB_REG_OBJ_DATA)
               begin
                  // out of range answers at once with zero, no store touched
                  if (sw_map[8])
                  begin
                     next_state = rfb_pkg::BUS_MEM;
                     next_wait  = 1'b1;
                  end
               end
               else if (avs_address == `RFB_REG_PD_SEL)
               begin
                  if (avs_write)
                     next_pd_sel = avs_writedata[`RFB_PD_SEL];
                  next_readdata[`RFB_PD_SEL] = pd_sel;
               end
               else if (avs_address == `RFB_REG_PD_OUT)
               begin
                  if (pd_sel < `RFB_BUS_MAX_WORDS)
                  begin
                     if (avs_write)
                        next_pd_out[pd_sel] = avs_writedata[`RFB_WORD];
                     next_readdata[`RFB_WORD] = pd_out[pd_sel];
                  end
               end
               else if (avs_address == `RFB_REG_PD_IN)
               begin
                  if (pd_sel < `RFB_BUS_MAX_WORDS)
                     next_readdata[`RFB_WORD] = pd_in[pd_sel];
               end
            end
         end
         rfb_pkg::BUS_MEM:
         begin
            if (!obj_req)
               next_state = rfb_pkg::BUS_MEMRD;
         end
         rfb_pkg::BUS_MEMRD:
         begin
            next_state               = rfb_pkg::BUS_DONE;
            next_wait                = 1'b0;
            next_readdata            = 32'h0000_0000;
            next_readdata[`RFB_WORD] = mem_rdata;
         end
         default:
            next_state = rfb_pkg::BUS_IDLE;
      endcase
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state           <= rfb_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         pcp_sel         <= rfb_pkg::PCP_NONE;
         pd_len          <= 5'h00;
         param_len       <= 8'h00;
         irq_stat        <= '0;
         irq_mask        <= '0;
         irq             <= 1'b0;
         obj_index_r     <= `RFB_OBJ_RW_BASE;
         pd_sel          <= 4'h0;
         pd_out          <= '{default: 16'h0000};
      end
      else if (ce)
      begin
         state           <= next_state;
         avs_waitrequest <= next_wait;
         avs_readdata    <= next_readdata;
         pcp_sel         <= next_pcp_sel;
         pd_len          <= next_pd_len;
         param_len       <= next_param_len;
         irq_stat        <= next_irq_stat;
         irq_mask        <= next_irq_mask;
         irq             <= next_irq;
         obj_index_r     <= next_obj_index_r;
         pd_sel          <= next_pd_sel;
         pd_out          <= next_pd_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus slots, process image and indicators
   for (genvar g = 0; g < 10; g++)
   begin : g_pd_in
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            pd_in[g] <= 16'h0000;
         else if (ce && word_strobe && !cycle_start && slot == 4'(g) && slot < pd_words)
            pd_in[g] <= word_rx;
      end
   end

   always_comb
   begin
      next_slot = slot;
      if (cycle_start)
         next_slot = 4'h0;
      else if (word_strobe && slot < `RFB_BUS_MAX_WORDS)
         next_slot = slot + 4'h1;
      next_word_tx = (next_slot < pd_words) ? pd_out[next_slot] : 16'h0000;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot                 <= 4'h0;
         word_tx              <= 16'h0000;
         lk_p                 <= 1'b0;
         lk_pwr               <= 1'b0;
         lk_perr              <= 1'b0;
         obj_ack              <= 1'b0;
         obj_err              <= 1'b0;
         obj_rdata            <= 16'h0000;
         out_seg_enable       <= 1'b0;
         out_term_enable      <= 1'b1;
         outgoing_bus_off_led <= 1'b1;
         cable_ok_led         <= 1'b0;
         bus_active_led       <= 1'b0;
         id_code              <= 8'h00;
      end
      else if (ce)
      begin
         slot                 <= next_slot;
         word_tx              <= next_word_tx;
         lk_p                 <= obj_req;
         lk_pwr               <= obj_wr;
         lk_perr              <= lk_err;
         obj_ack              <= lk_p;
         obj_err              <= lk_p && lk_perr;
         obj_rdata            <= (lk_p && !lk_perr && !lk_pwr) ? mem_rdata : 16'h0000;
         out_seg_enable       <= !seg_off;
         out_term_enable      <= seg_off;
         outgoing_bus_off_led <= seg_off;
         cable_ok_led         <= cable_s && !mreset_s;
         bus_active_led       <= dll_active;
         id_code              <= id_sel;
      end
   end

   // 0.6 s at 200 MHz is far too long to simulate: shrink HOLD_CYCLES in tests
   rfb_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) i_rfb_hold_timer
   (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .trig  (pcp_act),
      .lit   (param_traffic_led)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   pd_len_cap_a: assert property (pd_len <= `RFB_PD_MAX_BYTES)
      else $error("process length above cap");
   param_cap_a: assert property (9'(param_len) + 9'(pd_len) <= 9'(`RFB_STRING_MAX_BYTES))
      else $error("parameter string above cap");
   id_code_a: assert property ($stable(pcp_sel) [*2] |-> id_code == id_sel)
      else $error("identity code does not match channel width");
   ro_write_err_a: assert property (obj_req && obj_wr && obj_index >= `RFB_OBJ_RO_BASE
                                    |-> ##2 obj_ack && obj_err)
      else $error("read-only object write not refused");
   term_on_a: assert property (outgoing_term_sense [*4] |-> out_term_enable && !out_seg_enable)
      else $error("outgoing segment not terminated");
   bus_off_led_a: assert property (outgoing_bus_off_led == !out_seg_enable)
      else $error("bus-off indicator disagrees with segment");
   traffic_hold_a: assert property (obj_req |=> param_traffic_led [*8])
      else $error("traffic indicator not held");
   cable_led_a: assert property ((cable_good && !bus_master_reset) [*4] |-> cable_ok_led)
      else $error("cable indicator dark");
   bus_led_a: assert property (dll_active |=> bus_active_led)
      else $error("bus-active indicator not following");
   pd_capture_a: assert property (word_strobe && !cycle_start && slot == 4'h0 && pd_words != 4'h0
                                  |=> pd_in[0] == $past(word_rx))
      else $error("process word not captured");
   slot_budget_a: assert property (pd_words + pcp_words <= `RFB_BUS_MAX_WORDS)
      else $error("bus words exceed budget");

   obj_read_c: cover property (obj_req && !obj_wr ##2 obj_ack && !obj_err);
   seg_off_c: cover property ($rose(outgoing_bus_off_led));
   irq_c: cover property ($rose(irq));
   sw_obj_c: cover property (state == rfb_pkg::BUS_MEMRD ##1 !avs_waitrequest);
endmodule
`default_nettype wire

// *** dv/rfb_link_model.sv ***
// link master model: bus slots and parameter object requests
`timescale 1ns/1ps
`default_nettype none
module rfb_link_model
(
   input  wire logic        clk,
   output var  logic        cycle_start,
   output var  logic        word_strobe,
   output var  logic [15:0] word_rx,
   output var  logic        obj_req,
   output var  logic        obj_wr,
   output var  logic [15:0] obj_index,
   output var  logic [15:0] obj_wdata
);
   initial {cycle_start, word_strobe, word_rx, obj_req, obj_wr, obj_index, obj_wdata} = '0;
   // released fields show the inverse, never a stale copy
   task automatic obj(input logic w, input logic [15:0] i, d);
      @(posedge clk);
      {obj_req, obj_wr, obj_index, obj_wdata} <= {1'b1, w, i, d};
      @(posedge clk);
      {obj_req, obj_wr, obj_index, obj_wdata} <= {1'b0, ~w, ~i, ~d};
   endtask
   task automatic slot(input logic s, input logic [15:0] d);
      @(posedge clk);
      {cycle_start, word_strobe, word_rx} <= {s, ~s, d};
      @(posedge clk);
      {cycle_start, word_strobe, word_rx} <= {2'b0, ~d};
   endtask
endmodule
`default_nettype wire

// *** dv/tb_rfb_adapter.sv ***
// self-checking testbench of the ring fieldbus slave adapter
`timescale 1ns/1ps
`default_nettype none
`include "rfb_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_rfb_adapter;
   localparam int unsigned HOLD = 20;
   logic clk = 0, resetn = 0, ce = 1, rd = 0, wr = 0, sense = 0, cab = 0, mrst = 0, dll = 0;
   logic [3:0]  adr = '0;
   logic [31:0] wd = '0, rdata, q;
   logic [15:0] word_tx, odat, wrx, oi, owd;
   logic [7:0]  idc;
   logic wreq, irq, cs, ws, oq, ow, ack, err, seg, term, led_off, led_tr, led_cc, led_ba;
   int bad_count = 0, n_tests = 0;
   always #2.5 clk = ~clk;
   rfb_link_model i_rfb_link_model (.clk, .cycle_start(cs), .word_strobe(ws), .word_rx(wrx), .obj_req(oq),
      .obj_wr(ow), .obj_index(oi), .obj_wdata(owd));
   rfb_adapter #(.HOLD_CYCLES(HOLD)) i_rfb_adapter (.clk, .resetn, .ce, .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq), .irq, .cycle_start(cs),
      .word_strobe(ws), .word_rx(wrx), .word_tx, .obj_req(oq), .obj_wr(ow), .obj_index(oi), .obj_wdata(owd),
      .obj_ack(ack), .obj_rdata(odat), .obj_err(err), .dll_active(dll), .cable_good(cab),
      .bus_master_reset(mrst), .outgoing_term_sense(sense), .out_seg_enable(seg), .out_term_enable(term),
      .id_code(idc), .outgoing_bus_off_led(led_off), .param_traffic_led(led_tr), .cable_ok_led(led_cc),
      .bus_active_led(led_ba));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one register access; a hung slave ends the run
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      {wr, rd, adr, wd} <= {w, ~w, a, d};
      do @(posedge clk); while (wreq !== 1'b0 && ++n < 50);
      if (wreq !== 1'b0)
      begin
         bad_count++;
         final_report();
      end
      q = rdata;
      {wr, rd} <= 2'b0;
   endtask
   task automatic lk(input logic w, input logic [15:0] i, d, input logic e, input logic [15:0] r);
      i_rfb_link_model.obj(w, i, d);
      @(posedge clk);
      #1;
      `CHK("ack", 1'b1, ack)
      `CHK("err", e, err)
      `CHK("odat", r, odat)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_cfg;
      int pdl;
      for (int k = 0; k < 4; k++)
      begin
         pdl = (k == 3) ? 12 : 20 - 2 * k;
         av(1, `RFB_REG_CTRL, {19'h0, 5'd20, 6'h0, k[1:0]});
         av(0, `RFB_REG_ID, 0);
         `CHK("id", 32'h21 + k, q)
         av(0, `RFB_REG_CTRL, 0);
         `CHK("pdlen", pdl, q[12:8])
         av(1, `RFB_REG_PARAM_LEN, 32'hff);
         av(0, `RFB_REG_PARAM_LEN, 0);
         `CHK("plen", 200 - pdl, q)
      end
      $display("cfg done");
   endtask
   task automatic t_obj;
      av(1, `RFB_REG_IRQ_MASK, 32'h8);
      av(1, `RFB_REG_OBJ_INDEX, 32'h6040);
      av(1, `RFB_REG_OBJ_DATA, 32'hbeef);
      lk(1, 16'h6001, 16'h1234, 0, 0);
      `CHK("irq", 1'b1, irq)
      lk(0, 16'h6001, 0, 0, 16'h1234);
      lk(1, 16'h6040, 16'h5555, 1, 0);
      lk(0, 16'h6040, 0, 0, 16'hbeef);
      lk(0, 16'h6080, 0, 1, 0);
      lk(0, 16'h5fff, 0, 1, 0);
      `CHK("trled", 1'b1, led_tr)
      repeat (HOLD + 3) @(posedge clk);
      #1;
      `CHK("trhold", 1'b0, led_tr)
      av(1, `RFB_REG_IRQ_STAT, 32'h1f);
      av(1, `RFB_REG_IRQ_MASK, 0);
      lk(1, 16'h6002, 16'h1, 0, 0);
      `CHK("irqmask", 1'b0, irq)
      av(0, `RFB_REG_IRQ_STAT, 0);
      `CHK("irqstat", 32'ha, q)
      $display("obj done");
   endtask
   // sense grounded whenever a further module follows
   task automatic pins(input logic s, c, m, d);
      @(posedge clk);
      {sense, cab, mrst, dll} <= {s, c, m, d};
      repeat (4) @(posedge clk);
      #1;
      `CHK("term", s, term)
      `CHK("seg", ~s, seg)
      `CHK("offled", s, led_off)
      `CHK("ccled", c & ~m, led_cc)
      `CHK("baled", d, led_ba)
   endtask
   task automatic t_pd;
      av(1, `RFB_REG_PD_SEL, 0);
      av(1, `RFB_REG_PD_OUT, 32'ha5a5);
      av(1, `RFB_REG_PD_SEL, 1);
      av(1, `RFB_REG_PD_OUT, 32'h5a5a);
      i_rfb_link_model.slot(1, 0);
      #1;
      `CHK("slot0", 16'ha5a5, word_tx)
      i_rfb_link_model.slot(0, 16'h1357);
      #1;
      `CHK("slot1", 16'h5a5a, word_tx)
      av(1, `RFB_REG_PD_SEL, 0);
      av(0, `RFB_REG_PD_IN, 0);
      `CHK("pdin", 32'h1357, q)
      for (int s = 0; s < 5; s++)
         i_rfb_link_model.slot(0, 16'h0);
      #1;
      `CHK("pdled", 1'b0, led_tr)
      i_rfb_link_model.slot(0, 16'h0);
      #1;
      `CHK("chanled", 1'b1, led_tr)
      $display("pd done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("idrst", 8'h21, idc)
      t_cfg;
      t_obj;
      for (int k = 0; k < 16; k++)
         pins(k[3], k[2], k[1], k[0]);
      $display("pins done");
      t_pd;
      final_report;
   end
endmodule
`default_nettype wire
